//--- verilog/swwc_ctl.sv
// system clock switch, wake-up, watchdog, interrupt gating and timer block
`timescale 1ns/1ps
// What this block does
// RL1: a pin wakes from halt only if input and its wake-enable bit set
// RL2: port a bit 5 output is open-drain, drives low only
// RL3: port a bit 5 has no internal pull-up
// RL4: clock mode bit 0 set with bit 5 input makes it active-low reset
// RL5: entering interrupt service clears the global interrupt enable
// RL6: enable and request registers undefined at reset; software inits first
// RL7: software never switches source and kills old oscillator together
// RL8: write 0x36 selects high rc div 2, low rc stays until bit 2 cleared
// RL9: watchdog stops whenever the low rc oscillator is disabled
// RL10: watchdog counts through both halts; timeout then resets device
// RL11: watchdog ticks from low rc normally, from system clock in fast wake
// RL12: software disables watchdog before halt, re-enables after fast wake off
// RL13: misc register picks fast wake or normal wake with watchdog period
// RL14: timer bit 8 rising edges request interrupts, every 512 counts
// RL15: after timer restart next interrupt at next bit 8 rising edge
// RL16: lvr threshold honoured only after power-on completes
// RL17: osc/lvr bit 0 set disables low-voltage reset
// RL18: cpu-only halt gates core clock, oscillators keep running
// RL19: return from interrupt sets global interrupt enable again
module swwc_ctl
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // cpu events
  input wire logic i_halt_sys,
  input wire logic i_halt_cpu,
  input wire logic i_irq_ack,
  input wire logic i_reti,
  input wire logic i_gie_set,
  input wire logic i_gie_clr,
  input wire logic i_wdt_clear,
  input wire logic i_t16_restart,
  // analog status
  input wire logic i_lvd_below,
  // port a pins
  input wire logic [7:0] i_port_a,
  output logic [7:0] o_port_a,
  output logic [7:0] o_port_a_oe,
  output logic [7:0] o_port_a_pu,
  // clock and reset control outputs
  output logic o_core_clk_en,
  output logic o_lrc_en,
  output logic o_hrc_en,
  output logic [2:0] o_clk_sel,
  output logic o_sys_reset,
  output logic [2:0] o_lvr_level,
  // interrupt request to the core
  output logic o_irq
);
  logic [7:0] clock_mode_reg_ff, misc_ff, osclvr_ff, wake_en_ff, dir_ff, out_ff, pu_ff;
  logic [7:0] irq_en_ff, irq_rq_ff;
  logic gie_ff;
  logic [15:0] rdata_ff, t16_ff;
  logic [7:0] pa_s1_ff, pa_s2_ff, pa_s3_ff;
  logic lvd_s1_ff, lvd_s2_ff;
  logic [10:0] lrc_cnt_ff;
  logic [10:0] hrc_cnt_ff;
  logic [15:0] rd_mux;
  logic [17:0] wdt_ff;
  logic [15:0] por_cnt_ff;
  logic por_done_ff;
  logic t16_b8_ff;
  logic rst_req_ff;
  swwc_pkg::swwc_pwr_type pwr_ff, nxt_pwr;

  // register decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction
  wire w_clock_mode_reg = i_wr && hit(i_addr, swwc_pkg::CLOCK_MODE_REG_OFS);
  wire w_misc = i_wr && hit(i_addr, swwc_pkg::MISC_OFS);
  wire w_osclvr = i_wr && hit(i_addr, swwc_pkg::OSCLVR_OFS);
  wire w_wake = i_wr && hit(i_addr, swwc_pkg::WAKEEN_OFS);
  wire w_dir = i_wr && hit(i_addr, swwc_pkg::PADIR_OFS);
  wire w_out = i_wr && hit(i_addr, swwc_pkg::PAOUT_OFS);
  wire w_pu = i_wr && hit(i_addr, swwc_pkg::PAPU_OFS);
  wire w_irqen = i_wr && hit(i_addr, swwc_pkg::IRQEN_OFS);
  wire w_irqrq = i_wr && hit(i_addr, swwc_pkg::IRQRQ_OFS);

  // derived controls
  wire lrc_on = clock_mode_reg_ff[swwc_pkg::CM_LRC_EN_BIT];
  wire fast_wake = misc_ff[swwc_pkg::MISC_FAST_BIT];
  wire wdt_on = clock_mode_reg_ff[swwc_pkg::CM_WDT_EN_BIT];
  wire [1:0] wdt_sel = misc_ff[swwc_pkg::MISC_WTP_LSB +: 2];
  wire [2:0] clk_sel = clock_mode_reg_ff[swwc_pkg::CM_SEL_LSB +: swwc_pkg::CM_SEL_W];
  wire sel_lrc = (clk_sel == swwc_pkg::SEL_LRC);
  wire lrc_tick = lrc_on && (lrc_cnt_ff == 11'(swwc_pkg::LRC_DIV - 1));
  wire hrc_tick = (hrc_cnt_ff == swwc_pkg::HRC_DIV - 11'h0_001);
  // system clock enable pulse from the chosen source
  wire sys_tick = sel_lrc ? lrc_tick : hrc_tick;
  wire halted = (pwr_ff != swwc_pkg::RUN);

  // RL1: wake needs input direction and enable
  // edge taken after the synchroniser, so a metastable first stage never reaches it
  wire [7:0] wake_hit = (pa_s2_ff ^ pa_s3_ff) & ~dir_ff & wake_en_ff;

  // RL4: external reset, only while pin is input
  wire ext_rst = clock_mode_reg_ff[swwc_pkg::CM_EXTRST_BIT] && !dir_ff[swwc_pkg::EXTRST_PIN]
                 && !pa_s2_ff[swwc_pkg::EXTRST_PIN];

  // RL11: watchdog tick source by wake mode
  wire wdt_tick = fast_wake ? sys_tick : lrc_tick;
  wire [17:0] wdt_lim = (wdt_sel == 2'd0) ? swwc_pkg::WDT_P0 :
                        (wdt_sel == 2'd1) ? swwc_pkg::WDT_P1 :
                        (wdt_sel == 2'd2) ? swwc_pkg::WDT_P2 : swwc_pkg::WDT_P3;
  // RL9: low rc off freezes the watchdog
  wire wdt_run = wdt_on && lrc_on;
  // RL10: no halt term, so the watchdog keeps counting
  wire wdt_to = wdt_run && (wdt_ff >= wdt_lim);

  // RL16: lvr gated until power-on done
  // RL17: disable bit kills lvr
  wire lvr_fire = por_done_ff && !osclvr_ff[swwc_pkg::OL_LVR_DIS_BIT] && lvd_s2_ff;

  // RL14: rising edge of timer bit 8
  wire t16_edge = t16_ff[swwc_pkg::T16_IRQ_BIT] && !t16_b8_ff;
  wire [7:0] irq_set = ({7'h0_0, 1'b0} | (8'h0_1 << swwc_pkg::IRQ_T16)) & {8{t16_edge}}
                       | ({8{|wake_hit}} & (8'h0_1 << swwc_pkg::IRQ_PIN));

  // power state machine
  always_comb
  begin
    nxt_pwr = pwr_ff;
    case (pwr_ff)
      swwc_pkg::RUN:
      begin
        if (i_halt_sys)
          nxt_pwr = swwc_pkg::HALT_SYS;
        else if (i_halt_cpu)
          nxt_pwr = swwc_pkg::HALT_CPU;
      end
      swwc_pkg::HALT_SYS, swwc_pkg::HALT_CPU:
      begin
        if (|wake_hit)
          nxt_pwr = swwc_pkg::RUN;
      end
      default: nxt_pwr = swwc_pkg::RUN;
    endcase
  end

  // pin synchronisers
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pa_s1_ff <= 8'h0_0;
      pa_s2_ff <= 8'h0_0;
      pa_s3_ff <= 8'h0_0;
      lvd_s1_ff <= 1'b0;
      lvd_s2_ff <= 1'b0;
    end
    else
    begin
      pa_s1_ff <= i_port_a;
      pa_s2_ff <= pa_s1_ff;
      pa_s3_ff <= pa_s2_ff;
      lvd_s1_ff <= i_lvd_below;
      lvd_s2_ff <= lvd_s1_ff;
    end
  end

  // software registers; clock mode writes go through as written
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clock_mode_reg_ff <= swwc_pkg::CLOCK_MODE_REG_RST;
      misc_ff <= swwc_pkg::MISC_RST;
      osclvr_ff <= swwc_pkg::OSCLVR_RST;
      wake_en_ff <= 8'h0_0;
      dir_ff <= 8'h0_0;
      out_ff <= 8'h0_0;
      pu_ff <= 8'h0_0;
    end
    else
    begin
      // RL8: write 0x36 just stores source and enables
      if (w_clock_mode_reg)
        clock_mode_reg_ff <= i_wdata[7:0];
      // RL13: one write sets period and fast wake bit together
      if (w_misc)
        misc_ff <= i_wdata[7:0];
      if (w_osclvr)
        osclvr_ff <= i_wdata[7:0];
      if (w_wake)
        wake_en_ff <= i_wdata[7:0];
      if (w_dir)
        dir_ff <= i_wdata[7:0];
      if (w_out)
        out_ff <= i_wdata[7:0];
      if (w_pu)
        pu_ff <= i_wdata[7:0];
    end
  end

  // interrupt registers, no meaningful reset value for software
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      // RL6: cleared here only to keep sim defined
      irq_en_ff <= 8'h0_0;
      irq_rq_ff <= 8'h0_0;
    end
    else
    begin
      if (w_irqen)
        irq_en_ff <= i_wdata[7:0];
      // write one clears; a new event wins
      irq_rq_ff <= (w_irqrq ? (irq_rq_ff & ~i_wdata[7:0]) : irq_rq_ff) | irq_set;
    end
  end

  // global enable
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      gie_ff <= 1'b0;
    // RL5: service entry clears enable
    else if (i_irq_ack || i_gie_clr)
      gie_ff <= 1'b0;
    // RL19: return restores enable
    else if (i_reti || i_gie_set)
      gie_ff <= 1'b1;
  end

  // oscillator dividers; high rc free running, low rc held at zero while disabled
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lrc_cnt_ff <= 11'h0_00;
      hrc_cnt_ff <= 11'h0_00;
    end
    else
    begin
      lrc_cnt_ff <= (!lrc_on || lrc_tick) ? 11'h0_00 : lrc_cnt_ff + 11'h0_01;
      hrc_cnt_ff <= hrc_tick ? 11'h0_00 : hrc_cnt_ff + 11'h0_01;
    end
  end

  // watchdog counter and reset request
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wdt_ff <= 18'h0_0000;
      rst_req_ff <= 1'b0;
    end
    else
    begin
      if (!wdt_on || i_wdt_clear || wdt_to)
        wdt_ff <= 18'h0_0000;
      else if (wdt_run && wdt_tick)
        wdt_ff <= wdt_ff + 18'h0_0001;
      rst_req_ff <= wdt_to || ext_rst || lvr_fire;
    end
  end

  // power-on completion timer
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      por_cnt_ff <= 16'h0_000;
      por_done_ff <= 1'b0;
    end
    else if (!por_done_ff)
    begin
      por_cnt_ff <= por_cnt_ff + 16'h0_001;
      por_done_ff <= (por_cnt_ff == 16'(swwc_pkg::POR_CYC - 1));
    end
  end

  // 16-bit timer, counts only while system clock runs
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      t16_ff <= 16'h0_000;
      t16_b8_ff <= 1'b0;
    end
    // RL15: restart clears edge history too
    else if (i_t16_restart)
    begin
      t16_ff <= 16'h0_000;
      t16_b8_ff <= 1'b0;
    end
    else
    begin
      t16_b8_ff <= t16_ff[swwc_pkg::T16_IRQ_BIT];
      if (sys_tick && pwr_ff != swwc_pkg::HALT_SYS)
        t16_ff <= t16_ff + 16'h0_001;
    end
  end

  // state and read data
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pwr_ff <= swwc_pkg::RUN;
      rdata_ff <= 16'h0_000;
    end
    else
    begin
      pwr_ff <= nxt_pwr;
      rdata_ff <= i_rd ? rd_mux : 16'h0_000;
    end
  end

  // read mux; unmapped reads zero
  always_comb
  begin
    case (i_addr)
      swwc_pkg::CLOCK_MODE_REG_OFS: rd_mux = {8'h0_0, clock_mode_reg_ff};
      swwc_pkg::MISC_OFS: rd_mux = {8'h0_0, misc_ff};
      swwc_pkg::OSCLVR_OFS: rd_mux = {8'h0_0, osclvr_ff};
      swwc_pkg::WAKEEN_OFS: rd_mux = {8'h0_0, wake_en_ff};
      swwc_pkg::PADIR_OFS: rd_mux = {8'h0_0, dir_ff};
      swwc_pkg::PAOUT_OFS: rd_mux = {8'h0_0, out_ff};
      swwc_pkg::PAPU_OFS: rd_mux = {8'h0_0, pu_ff};
      swwc_pkg::IRQEN_OFS: rd_mux = {8'h0_0, irq_en_ff};
      swwc_pkg::IRQRQ_OFS: rd_mux = {8'h0_0, irq_rq_ff};
      swwc_pkg::T16_OFS: rd_mux = t16_ff;
      swwc_pkg::STAT_OFS: rd_mux = {8'h0_0, por_done_ff, gie_ff, wdt_ff[17], 2'b00, pwr_ff};
      swwc_pkg::PAIN_OFS: rd_mux = {8'h0_0, pa_s2_ff};
      default: rd_mux = 16'h0_000;
    endcase
  end

  // pin drive
  genvar g;
  generate
    for (g = 0; g < swwc_pkg::PORT_W; g++)
    begin : g_pin
      if (g == swwc_pkg::EXTRST_PIN)
      begin : g_od
        // RL2: open-drain, only pulls low
        assign o_port_a[g] = 1'b0;
        assign o_port_a_oe[g] = dir_ff[g] && !out_ff[g];
        // RL3: never a pull-up here
        assign o_port_a_pu[g] = 1'b0;
      end
      else
      begin : g_pp
        assign o_port_a[g] = out_ff[g];
        assign o_port_a_oe[g] = dir_ff[g];
        assign o_port_a_pu[g] = pu_ff[g];
      end
    end
  endgenerate

  assign o_rdata = rdata_ff;
  // RL18: core clock gated in either halt, oscillators stay as programmed except high rc off in system halt
  assign o_core_clk_en = !halted;
  assign o_lrc_en = lrc_on;
  assign o_hrc_en = clock_mode_reg_ff[swwc_pkg::CM_HRC_EN_BIT] && pwr_ff != swwc_pkg::HALT_SYS;
  assign o_clk_sel = clk_sel;
  assign o_sys_reset = rst_req_ff;
  assign o_lvr_level = osclvr_ff[swwc_pkg::OL_LVR_LSB +: 3];
  assign o_irq = gie_ff && |(irq_rq_ff & irq_en_ff);
endmodule

//--- verilog/swwc_pkg.sv
// constants for the system clock, wake-up and watchdog control block
package swwc_pkg;
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] CLOCK_MODE_REG_OFS = 8'h00;
  localparam logic [7:0] MISC_OFS = 8'h04;
  localparam logic [7:0] OSCLVR_OFS = 8'h08;
  localparam logic [7:0] WAKEEN_OFS = 8'h0C;
  localparam logic [7:0] PADIR_OFS = 8'h10;
  localparam logic [7:0] PAOUT_OFS = 8'h14;
  localparam logic [7:0] PAPU_OFS = 8'h18;
  localparam logic [7:0] IRQEN_OFS = 8'h1C;
  localparam logic [7:0] IRQRQ_OFS = 8'h20;
  localparam logic [7:0] T16_OFS = 8'h24;
  localparam logic [7:0] STAT_OFS = 8'h28;
  localparam logic [7:0] PAIN_OFS = 8'h2C;
  // clock mode fields
  localparam int CM_EXTRST_BIT = 0;
  localparam int CM_WDT_EN_BIT = 1;
  localparam int CM_LRC_EN_BIT = 2;
  localparam int CM_HRC_EN_BIT = 4;
  localparam int CM_SEL_LSB = 5;
  localparam int CM_SEL_W = 3;
  localparam logic [7:0] CLOCK_MODE_REG_RST = 8'h0_4;
  // source select codes: lrc, hrc/2
  localparam logic [2:0] SEL_HRC_DIV2 = 3'h1;
  localparam logic [2:0] SEL_LRC = 3'h0;
  // misc fields
  localparam int MISC_FAST_BIT = 5;
  localparam int MISC_WTP_LSB = 0;
  localparam logic [7:0] MISC_RST = 8'h0_0;
  // osc / lvr fields
  localparam int OL_LVR_DIS_BIT = 0;
  localparam int OL_LVR_LSB = 1;
  localparam logic [7:0] OSCLVR_RST = 8'h0_0;
  localparam int T16_IRQ_BIT = 8;
  localparam int IRQ_T16 = 2;
  localparam int IRQ_PIN = 0;
  localparam int PORT_W = 8;
  localparam int EXTRST_PIN = 5;
  // low rc divider for 40 MHz system clock, nominal 20 kHz
  localparam int LRC_HZ = 20000;
  localparam int SYS_HZ = 40000000;
  localparam int LRC_DIV = SYS_HZ / LRC_HZ;
  localparam logic [10:0] HRC_DIV = 11'h0_002;
  localparam logic [7:0] T16_DIV = 8'h0_01;
  // watchdog periods by setting, in watchdog ticks
  localparam logic [17:0] WDT_P0 = 18'h0_0800;
  localparam logic [17:0] WDT_P1 = 18'h0_2000;
  localparam logic [17:0] WDT_P2 = 18'h0_8000;
  localparam logic [17:0] WDT_P3 = 18'h2_0000;
  // power-on settle time before lvr threshold is honoured
  localparam int POR_US = 100;
  localparam int POR_CYC = POR_US * (SYS_HZ / 1000000);
  typedef enum logic [2:0] {
    RUN = 3'b001,
    HALT_SYS = 3'b010,
    HALT_CPU = 3'b100
  } swwc_pwr_type;
endpackage

//--- tb/swwc_ctl_assertions.sv
// port-level assertions for the clock, wake and watchdog control block
`timescale 1ns/1ps
module swwc_ctl_chk
(
  // clock, reset and stimulus
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_halt_cpu,
  input wire logic i_irq_ack,
  // watched outputs
  input wire logic [7:0] o_port_a,
  input wire logic [7:0] o_port_a_pu,
  input wire logic o_core_clk_en,
  input wire logic o_lrc_en,
  input wire logic o_hrc_en,
  input wire logic [2:0] o_clk_sel,
  input wire logic [2:0] o_lvr_level,
  input wire logic o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // steps after a halt or a service entry, one cycle of slack for a registered output
  sequence s_gated;
    ##[0:1] !o_core_clk_en;
  endsequence
  sequence s_irq_off;
    ##[0:1] !o_irq;
  endsequence
  a_od_low_only: assert property (o_port_a[5] == 1'b0) else $error("pin 5 driven high");
  a_no_pullup: assert property (o_port_a_pu[5] == 1'b0) else $error("pin 5 pull-up on");
  a_irq_ack_off: assert property (i_irq_ack |=> s_irq_off) else $error("irq still high in service");
  a_halt_gate: assert property (i_halt_cpu |=> s_gated) else $error("core clock runs in halt");
  a_osc_kept: assert property (i_halt_cpu |=> $stable(o_lrc_en) && $stable(o_hrc_en))
    else $error("oscillator changed by halt");
  a_clk_sel: assert property (i_wr && i_addr == swwc_pkg::CLOCK_MODE_REG_OFS |=> o_clk_sel == $past(i_wdata[7:5]))
    else $error("clock select mismatch");
  a_osc_en: assert property (i_wr && i_addr == swwc_pkg::CLOCK_MODE_REG_OFS |=>
    o_lrc_en == $past(i_wdata[2]) && o_hrc_en == $past(i_wdata[4])) else $error("oscillator enable mismatch");
  a_lvr_level: assert property (i_wr && i_addr == swwc_pkg::OSCLVR_OFS |=> o_lvr_level == $past(i_wdata[3:1]))
    else $error("lvr level mismatch");
endmodule
bind swwc_ctl swwc_ctl_chk u_swwc_ctl_chk
(
  .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_halt_cpu(i_halt_cpu), .i_irq_ack(i_irq_ack), .o_port_a(o_port_a), .o_port_a_pu(o_port_a_pu),
  .o_core_clk_en(o_core_clk_en), .o_lrc_en(o_lrc_en), .o_hrc_en(o_hrc_en), .o_clk_sel(o_clk_sel),
  .o_lvr_level(o_lvr_level), .o_irq(o_irq)
);

//--- tb/swwc_ctl_bench.sv
// self-checking bench for the clock, wake and watchdog control block
`timescale 1ns/1ps
module swwc_ctl_bench;
  logic i_sys_clk, i_arst_n, i_wr, i_rd, i_lvd_below;
  logic [7:0] i_addr, i_port_a, ev;
  logic [15:0] i_wdata, v;
  wire logic i_halt_sys, i_halt_cpu, i_irq_ack, i_reti, i_gie_set, i_gie_clr, i_wdt_clear, i_t16_restart;
  wire logic [15:0] o_rdata;
  wire logic [7:0] o_port_a, o_port_a_oe, o_port_a_pu;
  wire logic o_core_clk_en, o_lrc_en, o_hrc_en, o_sys_reset, o_irq;
  wire logic [2:0] o_clk_sel, o_lvr_level;
  int miscompares, cmp_count, nrst, cycles;
  logic [31:0] seed;
  logic [7:0] cm [5] = '{8'h36, 8'h32, 8'h36, 8'h14, 8'h04};
  int gs [5] = '{4, 2, 3, 5, 4};
  logic [15:0] tt [5] = '{16'h00F0, 16'h0110, 16'h02F0, 16'h00F0, 16'h0110};
  // one pulse vector drives all core events
  assign {i_t16_restart, i_wdt_clear, i_gie_clr, i_gie_set, i_reti, i_irq_ack, i_halt_cpu, i_halt_sys} = ev;
  swwc_ctl u_swwc_ctl
  (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_halt_sys(i_halt_sys), .i_halt_cpu(i_halt_cpu), .i_irq_ack(i_irq_ack),
    .i_reti(i_reti), .i_gie_set(i_gie_set), .i_gie_clr(i_gie_clr), .i_wdt_clear(i_wdt_clear),
    .i_t16_restart(i_t16_restart), .i_lvd_below(i_lvd_below), .i_port_a(i_port_a), .o_port_a(o_port_a),
    .o_port_a_oe(o_port_a_oe), .o_port_a_pu(o_port_a_pu), .o_core_clk_en(o_core_clk_en),
    .o_lrc_en(o_lrc_en), .o_hrc_en(o_hrc_en), .o_clk_sel(o_clk_sel), .o_sys_reset(o_sys_reset),
    .o_lvr_level(o_lvr_level), .o_irq(o_irq)
  );
  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // hang ceiling and tally of cycles with reset high
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (o_sys_reset === 1'b1) nrst++;
    if (cycles == 40000)
    begin
      miscompares++;
      results();
    end
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(negedge i_sys_clk);
  endtask
  // read data only stands one cycle, so it is caught at the next falling edge
  task automatic rdv(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    v = o_rdata;
  endtask
  task automatic pls(input int k);
    @(posedge i_sys_clk);
    ev <= 8'h01 << k;
    @(posedge i_sys_clk);
    ev <= 8'h00;
    @(negedge i_sys_clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic ci(input logic e);
    cyc(2);
    chk("irq", o_irq, e);
  endtask
  task automatic tw(input logic [15:0] t);
    v = 16'h0000;
    for (int n = 0; n < 2000 && v < t; n++) rdv(swwc_pkg::T16_OFS);
  endtask
  task automatic results();
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    seed = 32'h0000_0013;
    {i_arst_n, i_wr, i_rd, ev, i_addr, i_wdata} = '0;
    {miscompares, cmp_count, nrst, cycles} = '0;
    i_lvd_below = 1'b1;
    i_port_a = 8'h20;
    repeat (6) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    cyc(40);
    chk("early reset", nrst, 0);
    @(posedge i_sys_clk) i_lvd_below <= 1'b0;
    rdv(swwc_pkg::CLOCK_MODE_REG_OFS);
    chk("clock mode", v, 16'h0004);
    rdv(8'h30);
    chk("unmapped", v, 16'h0000);
    // switch first, then stop; a stopped low rc freezes the dog
    wr(swwc_pkg::MISC_OFS, 16'h0020);
    foreach (cm[i])
    begin
      wr(swwc_pkg::CLOCK_MODE_REG_OFS, {8'h00, cm[i]});
      chk("clock select", o_clk_sel, cm[i][7:5]);
      chk("low rc", o_lrc_en, cm[i][2]);
      chk("high rc", o_hrc_en, cm[i][4]);
      pls(6);
      nrst = 0;
      // longer than a fast-wake timeout, so a running dog would bite
      cyc(cm[i] == 8'h32 ? 4500 : 4);
      chk("frozen dog", nrst, 0);
    end
    // fast wake bites in halt; normal wake is far slower
    pls(6);
    wr(swwc_pkg::CLOCK_MODE_REG_OFS, 16'h0036);
    pls(1);
    chk("core gated", o_core_clk_en, 0);
    chk("high rc kept", o_hrc_en, 1);
    nrst = 0;
    cyc(1900);
    chk("early bite", nrst, 0);
    cyc(2600);
    chk("bite in halt", nrst != 0, 1);
    // fast wake off before the dog runs on
    wr(swwc_pkg::MISC_OFS, 16'h0000);
    pls(6);
    nrst = 0;
    cyc(4500);
    chk("slow dog", nrst, 0);
    wr(swwc_pkg::CLOCK_MODE_REG_OFS, 16'h0034);
    repeat (20)
    begin
      v = rnd();
      wr(swwc_pkg::PADIR_OFS, {8'h00, v[7:0]});
      wr(swwc_pkg::PAOUT_OFS, {8'h00, v[15:8]});
      wr(swwc_pkg::PAPU_OFS, rnd());
      cyc(2);
      chk("drain enable", o_port_a_oe[5], v[5] & ~v[13]);
      chk("pull-up", o_port_a_pu[5], 0);
      chk("pin data", o_port_a, v[15:8] & 8'hDF);
    end
    // low pin resets only while an input
    wr(swwc_pkg::PADIR_OFS, 16'h0020);
    wr(swwc_pkg::CLOCK_MODE_REG_OFS, 16'h0035);
    @(posedge i_sys_clk) i_port_a <= 8'h00;
    nrst = 0;
    cyc(10);
    chk("pin as output", nrst, 0);
    wr(swwc_pkg::PADIR_OFS, 16'h0000);
    cyc(10);
    chk("pin reset", nrst != 0, 1);
    @(posedge i_sys_clk) i_port_a <= 8'h20;
    cyc(10);
    wr(swwc_pkg::CLOCK_MODE_REG_OFS, 16'h0034);
    // leave the cpu halt, init irq regs, then wake only from enabled inputs
    wr(swwc_pkg::PADIR_OFS, 16'h0001);
    wr(swwc_pkg::WAKEEN_OFS, 16'h0003);
    @(posedge i_sys_clk) i_port_a <= 8'h22;
    cyc(8);
    chk("cpu halt left", o_core_clk_en, 1);
    wr(swwc_pkg::IRQEN_OFS, 16'h0001);
    wr(swwc_pkg::IRQRQ_OFS, 16'h00FF);
    pls(0);
    @(posedge i_sys_clk) i_port_a <= 8'h27;
    cyc(8);
    chk("halted", o_core_clk_en, 0);
    rdv(swwc_pkg::STAT_OFS);
    chk("full halt", v[2:0], 3'h2);
    @(posedge i_sys_clk) i_port_a <= 8'h25;
    cyc(8);
    chk("woken", o_core_clk_en, 1);
    rdv(swwc_pkg::IRQRQ_OFS);
    chk("wake request", v[0], 1);
    // gie set, ack, return, clear, set
    ci(0);
    foreach (gs[i])
    begin
      pls(gs[i]);
      ci(i % 2 == 0);
    end
    wr(swwc_pkg::IRQEN_OFS, 16'h0000);
    ci(0);
    wr(swwc_pkg::IRQEN_OFS, 16'h0001);
    ci(1);
    wr(swwc_pkg::IRQRQ_OFS, 16'h0001);
    ci(0);
    // bit 8 edges only, restart realigns
    wr(swwc_pkg::IRQEN_OFS, 16'h0004);
    pls(7);
    wr(swwc_pkg::IRQRQ_OFS, 16'h00FF);
    foreach (tt[i])
    begin
      if (i == 3) pls(7);
      tw(tt[i]);
      rdv(swwc_pkg::IRQRQ_OFS);
      chk("timer request", v[2], tt[i] > 16'h0100 && tt[i] < 16'h0200);
      wr(swwc_pkg::IRQRQ_OFS, 16'h0004);
    end
    v = 16'h0000;
    for (int n = 0; n < 3000 && !v[7]; n++) rdv(swwc_pkg::STAT_OFS);
    chk("power-on done", v[7], 1);
    wr(swwc_pkg::OSCLVR_OFS, 16'h0003);
    chk("lvr level", o_lvr_level, 16'h0001);
    @(posedge i_sys_clk) i_lvd_below <= 1'b1;
    nrst = 0;
    cyc(10);
    chk("lvr off", nrst, 0);
    wr(swwc_pkg::OSCLVR_OFS, 16'h0002);
    cyc(10);
    chk("lvr on", nrst != 0, 1);
    results();
  end
endmodule
